//--- rtl/pgsl_regs.vh
`ifndef PGSL_REGS_VH
`define PGSL_REGS_VH
// ****************************************
// register indices, one 32-bit word each
// ****************************************
`define PGSL_IDX_STATUS 8'h08
`define PGSL_IDX_MASK 8'h0c
`define PGSL_IDX_CLEAR 8'h14
`define PGSL_IDX_ROUTE 8'h18
`define PGSL_IDX_CTRL 8'h32
`define PGSL_IDX_RAILS 8'h20
`define PGSL_IDX_STATE 8'h24
// ****************************************
// register byte addresses, four times the index so every word is aligned
// ****************************************
`define PGSL_OFF_STATUS 8'h20
`define PGSL_OFF_MASK 8'h30
`define PGSL_OFF_CLEAR 8'h50
`define PGSL_OFF_ROUTE 8'h60
`define PGSL_OFF_CTRL 8'hc8
`define PGSL_OFF_RAILS 8'h80
`define PGSL_OFF_STATE 8'h90
// ****************************************
// fields
// ****************************************
`define PGSL_CTRL_EN_BIT 7
`define PGSL_CTRL_BIDIR_BIT 5
`define PGSL_NEVT 7
`define PGSL_EVT_HICUR 0
`define PGSL_EVT_HITEMP 1
`define PGSL_EVT_PEC 2
`define PGSL_EVT_PARITY 3
`define PGSL_EVT_CRIT 4
`define PGSL_EVT_VINOV 5
`define PGSL_EVT_RAIL 6
`define PGSL_ROUTE_GSI 2'h1
`define PGSL_ROUTE_PG 2'h2
`define PGSL_ROUTE_RST 2'h1
`define PGSL_MASK_RST 7'h7f
`define PGSL_RAILS_RST 5'h1f
// ****************************************
// timing
// ****************************************
`define PGSL_LOW_PULSE_NS 1000
`define PGSL_CLK_NS 4
`define PGSL_LOW_PULSE_CYC ((`PGSL_LOW_PULSE_NS + `PGSL_CLK_NS - 1) / `PGSL_CLK_NS)
`endif

//--- rtl/pgsl_sync.v
`timescale 1ns/1ps
// two-flop synchroniser for the shared line
module pgsl_sync (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // level in and out
   input wire d_in,
   output wire q_out
);
   reg meta_r;
   reg sync_r;
   // first flop feeds only the second; idle level of the line is high
   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
      end else begin
         meta_r <= d_in;
         sync_r <= meta_r;
      end
   end
   assign q_out = sync_r;
endmodule // pgsl_sync

//--- rtl/pgsl_lowdet.v
`timescale 1ns/1ps
// detects the line held low for a minimum number of cycles
module pgsl_lowdet #(
   parameter CYC = 250,
   parameter W = 16
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // control
   input wire arm,
   input wire line_low,
   output wire hit
);
   reg [W-1:0] cnt_r;
   // counter saturates so a long hold gives a single hit
   always @(posedge aclk) begin
      if (!aresetn || !arm || !line_low) begin
         cnt_r <= {W{1'b0}};
      end else if (cnt_r != CYC[W-1:0]) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end
   assign hit = arm && line_low && (cnt_r == CYC[W-1:0] - 1'b1);
endmodule // pgsl_lowdet

//--- rtl/pgsl_top.v
// Functional notes
// - high current, warning, pec, parity: route 01 alert low, 10 none; clear releases.
// - critical temperature drives both pins low; only power cycle releases (code also releases both pins when mask bit 4 is cleared).
// - mask only gates pin assertion; status and other actions unchanged.
// - control bit 5 selects pin type, 0 output only (default), 1 bidirectional.
// - pin type may be written once, before any regulator enable.
// - pin type behaves the same in secure and programmable modes.
// - output-only mode ignores the sampled line level, except that line high still arms the fault latch.
// - release power-good only with valid bulk supply and all enabled rails good.
// - at first power-up hold power-good low while status still updates.
// - enable command turns rails on, enters regulation, releases the line.
// - output-only mode stays in regulation once the line is high.
// - not-good fault after line high drives low and latches until a fresh enable after disable.
// - bidirectional behaviour starts only after an enable command.
// - bidirectional mode moves to link monitor once the line is seen high.
// - bidirectional line held low minimum width disables rails and drives low.
`timescale 1ns/1ps
`include "pgsl_regs.vh"
module pgsl_top #(
   parameter LOW_CYC = `PGSL_LOW_PULSE_CYC
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // supply and events
   input wire bulk_input_supply,
   input wire [4:0] rail_good,
   input wire [`PGSL_NEVT-1:0] evt_in,
   input wire rail_enable_pin,
   input wire secure_mode,
   // power-good open-drain pin, oe low while driving low
   input wire power_ok_line_i,
   output wire power_ok_line_o,
   output wire power_ok_line_oe_n,
   // status alert pin and rail enables
   output reg status_alert_n,
   output reg [4:0] rail_on
);
   // ****************************************
   // states
   // ****************************************
   localparam ST_CFG = 2'd0;
   localparam ST_REG = 2'd1;
   localparam ST_MON = 2'd2;
   localparam ST_OFF = 2'd3;

   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [`PGSL_NEVT-1:0] status_r;
   reg [`PGSL_NEVT-1:0] mask_r;
   reg [1:0] route_r;
   reg [4:0] rails_en_r;
   reg bidir_r;
   reg cfg_locked_r;
   reg en_cmd_r;
   reg pg_low_r;
   reg pg_latch_r;
   reg seen_high_r;
   reg [7:0] waddr_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   reg aw_have_r;
   reg w_have_r;

   wire line_sync;
   wire ext_low_hit;
   wire do_write;
   wire [`PGSL_NEVT-1:0] clr_bits;
   wire enable_req;
   wire power_ok;
   wire crit_seen;

   // ****************************************
   // line synchroniser and low-pulse detector
   // ****************************************
   pgsl_sync u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d_in(power_ok_line_i),
      .q_out(line_sync)
   );

   // armed only in bidirectional mode after enable; output-only ignores the line
   pgsl_lowdet #(.CYC(LOW_CYC), .W(16)) u_low (
      .aclk(aclk),
      .aresetn(aresetn),
      .arm(bidir_r && (state_r == ST_MON) && !pg_low_r),
      .line_low(!line_sync),
      .hit(ext_low_hit)
   );

   // ****************************************
   // axi4-lite slave
   // ****************************************
   assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
   assign s_axi_wready = !w_have_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;

   // address and data may arrive in either order; held until both are in
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         waddr_r <= 8'h00;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            waddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(waddr_r) ? 2'h0 : 2'h2;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   function is_mapped;
      input [7:0] a;
      begin
         is_mapped = (a == `PGSL_OFF_STATUS) || (a == `PGSL_OFF_MASK) ||
            (a == `PGSL_OFF_CLEAR) || (a == `PGSL_OFF_ROUTE) ||
            (a == `PGSL_OFF_CTRL) || (a == `PGSL_OFF_RAILS) || (a == `PGSL_OFF_STATE);
      end
   endfunction

   function wr_hit;
      input [7:0] off;
      begin
         wr_hit = do_write && (waddr_r == off) && wstrb_r[0];
      end
   endfunction

   // read data path; unmapped addresses answer slverr with zero data
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= is_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
         case (s_axi_araddr)
            `PGSL_OFF_STATUS: s_axi_rdata <= {25'h0, status_r};
            `PGSL_OFF_MASK: s_axi_rdata <= {25'h0, mask_r};
            `PGSL_OFF_ROUTE: s_axi_rdata <= {30'h0, route_r};
            `PGSL_OFF_CTRL: s_axi_rdata <= {24'h0, en_cmd_r, 1'b0, bidir_r, 5'h0};
            `PGSL_OFF_RAILS: s_axi_rdata <= {27'h0, rails_en_r};
            `PGSL_OFF_STATE: s_axi_rdata <= {26'h0, cfg_locked_r, pg_latch_r,
               pg_low_r, seen_high_r, state_r};
            default: s_axi_rdata <= 32'h0;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************
   // configuration registers
   // ****************************************
   assign enable_req = rail_enable_pin || en_cmd_r;

   // pin type locks at the first enable of either kind
   always @(posedge aclk) begin
      if (!aresetn) begin
         bidir_r <= 1'b0;
         cfg_locked_r <= 1'b0;
         en_cmd_r <= 1'b0;
         mask_r <= `PGSL_MASK_RST;
         route_r <= `PGSL_ROUTE_RST;
         rails_en_r <= `PGSL_RAILS_RST;
      end else begin
         if (enable_req)
            cfg_locked_r <= 1'b1;
         if (wr_hit(`PGSL_OFF_CTRL)) begin
            en_cmd_r <= wdata_r[`PGSL_CTRL_EN_BIT];
            // one mode bit, independent of secure or programmable mode
            if (!cfg_locked_r && !enable_req)
               bidir_r <= wdata_r[`PGSL_CTRL_BIDIR_BIT];
         end else if (ext_low_hit) begin
            en_cmd_r <= 1'b0; // host low pulse acts as disable
         end
         if (wr_hit(`PGSL_OFF_MASK))
            mask_r <= wdata_r[`PGSL_NEVT-1:0];
         if (wr_hit(`PGSL_OFF_ROUTE))
            route_r <= wdata_r[1:0];
         if (wr_hit(`PGSL_OFF_RAILS))
            rails_en_r <= wdata_r[4:0];
      end
   end

   // ****************************************
   // event status, sticky; set wins over clear
   // ****************************************
   assign clr_bits = wr_hit(`PGSL_OFF_CLEAR) ? wdata_r[`PGSL_NEVT-1:0] : {`PGSL_NEVT{1'b0}};
   assign crit_seen = status_r[`PGSL_EVT_CRIT];

   // status keeps updating regardless of mask or state
   always @(posedge aclk) begin
      if (!aresetn) begin
         status_r <= {`PGSL_NEVT{1'b0}};
      end else begin
         // critical bit survives clear; only reset (power cycle) drops it
         status_r <= evt_in | (status_r & ~clr_bits) |
            ({`PGSL_NEVT{1'b0}} | (crit_seen << `PGSL_EVT_CRIT));
      end
   end

   // alert pin: mask gates only the pin, never the status
   always @(posedge aclk) begin
      if (!aresetn) begin
         status_alert_n <= 1'b1;
      end else begin
         status_alert_n <= !(((route_r == `PGSL_ROUTE_GSI) &&
            |(status_r & mask_r & ~(7'h1 << `PGSL_EVT_CRIT))) ||
            (crit_seen && mask_r[`PGSL_EVT_CRIT]));
      end
   end

   // ****************************************
   // power state machine
   // ****************************************
   assign power_ok = bulk_input_supply &&
      ((rail_good & rails_en_r) == rails_en_r) && !status_r[`PGSL_EVT_VINOV];

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_CFG: if (enable_req) state_nxt = ST_REG;
         ST_REG: begin
            if (!enable_req || ext_low_hit)
               state_nxt = ST_OFF;
            else if (line_sync && !pg_low_r && bidir_r)
               state_nxt = ST_MON;
            // output-only stays here once high
         end
         ST_MON: if (!enable_req || ext_low_hit) state_nxt = ST_OFF;
         ST_OFF: if (enable_req) state_nxt = ST_REG;
         default: state_nxt = ST_CFG;
      endcase
   end

   // seen_high marks the line high after regulation; in both modes it arms the fault latch
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= ST_CFG;
         seen_high_r <= 1'b0;
         pg_latch_r <= 1'b0;
         rail_on <= 5'h0;
      end else begin
         state_r <= state_nxt;
         rail_on <= ((state_nxt == ST_REG) || (state_nxt == ST_MON)) ? rails_en_r : 5'h0;
         if (state_r == ST_CFG || state_r == ST_OFF)
            seen_high_r <= 1'b0;
         else if (line_sync && !pg_low_r)
            seen_high_r <= 1'b1;
         // fault after line high latches; cleared by a fresh enable after disable
         if (seen_high_r && !power_ok && (state_r != ST_OFF))
            pg_latch_r <= 1'b1;
         else if (state_r == ST_OFF && state_nxt == ST_REG)
            pg_latch_r <= 1'b0;
      end
   end

   // ****************************************
   // power-good pin drive
   // ****************************************
   // low before enable, when off, when latched, when power not ok, or on an unmasked critical event; routed events never
   always @(posedge aclk) begin
      if (!aresetn) begin
         pg_low_r <= 1'b1;
      end else begin
         pg_low_r <= (state_nxt == ST_CFG) || (state_nxt == ST_OFF) ||
            pg_latch_r || !power_ok ||
            (crit_seen && mask_r[`PGSL_EVT_CRIT]) ||
            ((route_r == `PGSL_ROUTE_PG) && 1'b0);
      end
   end

   // release means float; the board pull-up sets the high level
   assign power_ok_line_o = 1'b0;
   assign power_ok_line_oe_n = !pg_low_r;
endmodule // pgsl_top

//--- tb/pgsl_top_checker.sv
`timescale 1ns/1ps
// ****
// port-level checks
// ****
module pgsl_chk (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // bus responses
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // supply, events, pins
   input wire bulk_input_supply,
   input wire [4:0] rail_good,
   input wire [6:0] evt_in,
   input wire power_ok_line_o,
   input wire power_ok_line_oe_n,
   input wire status_alert_n,
   input wire [4:0] rail_on
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   reg [2:0] crit_cnt_r;
   // counts a held critical event, saturating at 5; a gap before 5 or reset clears it
   always @(posedge aclk) begin
      if (!aresetn) crit_cnt_r <= 3'h0;
      else if (crit_cnt_r == 3'h5) crit_cnt_r <= crit_cnt_r;
      else if (evt_in[4]) crit_cnt_r <= crit_cnt_r + 3'h1;
      else crit_cnt_r <= 3'h0;
   end
   sequence pg_release;
      $rose(power_ok_line_oe_n);
   endsequence
   sequence rails_drop;
      rail_on != 5'h0 ##1 rail_on == 5'h0;
   endsequence
   od_low_only_a: assert property (power_ok_line_o == 1'b0)
      else $error("line driven high");
   reset_hold_a: assert property ($rose(aresetn) |-> !power_ok_line_oe_n && status_alert_n
      && rail_on == 5'h0) else $error("bad state after reset");
   release_supply_a: assert property (pg_release |-> $past(bulk_input_supply)
      && &$past(rail_good)) else $error("released while power not good");
   release_rails_a: assert property (pg_release |-> rail_on != 5'h0)
      else $error("released with rails off");
   alert_cause_a: assert property ($fell(status_alert_n) |-> ($past(evt_in)
      | $past(evt_in, 2) | $past(evt_in, 3)) != 7'h0) else $error("alert with no event");
   crit_stick_a: assert property (crit_cnt_r == 3'h5 |-> !status_alert_n
      && !power_ok_line_oe_n) else $error("critical event released");
   rail_off_a: assert property (rails_drop |-> ##[0:3] !power_ok_line_oe_n)
      else $error("rails off but line released");
   latch_hold_a: assert property ($fell(power_ok_line_oe_n) && rail_on != 5'h0
      |=> !power_ok_line_oe_n [*8]) else $error("latch released early");
   bresp_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   rresp_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
endmodule // pgsl_chk
bind pgsl_top pgsl_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .bulk_input_supply(bulk_input_supply), .rail_good(rail_good), .evt_in(evt_in),
   .power_ok_line_o(power_ok_line_o), .power_ok_line_oe_n(power_ok_line_oe_n),
   .status_alert_n(status_alert_n), .rail_on(rail_on));

//--- tb/pgsl_line_model.sv
`timescale 1ns/1ps
// ****
// shared line: pull-up, other modules and host pulling low
// ****
module pgsl_line_model (
   // clock
   input wire aclk,
   // our device and the far side
   input wire oe_n,
   input wire [7:0] hold_cyc,
   input wire go,
   output wire line
);
   reg [7:0] cnt_r = 8'h00;
   // far side holds the line low for hold_cyc cycles after go
   always @(posedge aclk) begin
      if (go) cnt_r <= hold_cyc;
      else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
   end
   // wired-and: high only by the pull-up when nobody pulls low
   assign line = oe_n & (cnt_r == 8'h00);
endmodule // pgsl_line_model

//--- tb/pgsl_top_tb_top.sv
`timescale 1ns/1ps
`include "pgsl_regs.vh"
// ****
// bench
// ****
module pgsl_top_tb_top;
   reg aclk = 1'b0;
   reg aresetn = 1'b0;
   reg [7:0] awaddr = 8'h00, araddr = 8'h00, hold = 8'h00;
   reg [31:0] wdata = 32'h0, rd;
   reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   reg bulk = 1'b1, smode = 1'b1, go = 1'b0, ha, hw, hb;
   reg [4:0] rgood = 5'h1f;
   reg [6:0] evt = 7'h00;
   reg [1:0] rs;
   wire awready, wready, bvalid, arready, rvalid, pg_o, pg_oe_n, alert_n, line;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [4:0] rail_on;
   integer failures = 0, n_tests = 0, cyc = 0, i, r;
   // rail_enable_pin grounded: bus enable only, bidirectional use allowed
   pgsl_top #(.LOW_CYC(4)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .bulk_input_supply(bulk), .rail_good(rgood), .evt_in(evt),
      .rail_enable_pin(1'b0), .secure_mode(smode), .power_ok_line_i(line),
      .power_ok_line_o(pg_o), .power_ok_line_oe_n(pg_oe_n), .status_alert_n(alert_n),
      .rail_on(rail_on));
   pgsl_line_model u_line (.aclk(aclk), .oe_n(pg_oe_n), .hold_cyc(hold), .go(go), .line(line));
   always #2 aclk = ~aclk;
   // hang guard
   always @(posedge aclk) begin
      cyc = cyc + 1;
      if (cyc == 8000) begin
         failures = failures + 1;
         complete_run;
      end
   end
   task complete_run;
      begin
         $display("tests=%0d failures=%0d", n_tests, failures);
         if (failures == 0 && n_tests > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   task chk(input [31:0] s, input [31:0] e);
      begin
         n_tests = n_tests + 1;
         if (s !== e) begin
            failures = failures + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
         end
      end
   endtask
   // lets n edges pass and stops where outputs are settled
   task tick(input integer n);
      begin
         repeat (n) @(posedge aclk);
         @(negedge aclk);
      end
   endtask
   // handshakes are judged at the falling edge, acted on at the next rising one
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge aclk);
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         hb = 1'b0;
         while (!hb) begin
            @(negedge aclk);
            ha = awvalid & awready;
            hw = wvalid & wready;
            hb = bvalid;
            rs = bresp;
            @(posedge aclk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            if (hb) bready <= 1'b0;
         end
      end
   endtask
   task rdr(input [7:0] a);
      begin
         @(posedge aclk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         hb = 1'b0;
         while (!hb) begin
            @(negedge aclk);
            ha = arvalid & arready;
            hb = rvalid;
            rd = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ha) arvalid <= 1'b0;
            if (hb) rready <= 1'b0;
         end
      end
   endtask
   task pulse(input [7:0] n);
      begin
         @(posedge aclk);
         hold <= n;
         go <= 1'b1;
         @(posedge aclk);
         go <= 1'b0;
      end
   endtask
   // main sequence
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      tick(2);
      chk(pg_oe_n, 0);
      rdr(`PGSL_OFF_CTRL);
      chk(rd[5], 0);
      rdr(`PGSL_OFF_ROUTE);
      chk(rd, 1);
      rdr(`PGSL_OFF_MASK);
      chk(rd, 32'h7f);
      rdr(8'h40);
      chk(rs, 2'h2);
      chk(rd, 32'h0);
      wr(8'h40, 32'h0);
      chk(rs, 2'h2);
      @(posedge aclk);
      evt <= 7'h01;
      tick(6);
      chk(pg_oe_n, 0);
      chk(alert_n, 0);
      rdr(`PGSL_OFF_STATUS);
      chk(rd[0], 1);
      evt <= 7'h00;
      wr(`PGSL_OFF_CLEAR, 1);
      chk(rs, 2'h0);
      pulse(30);
      wr(`PGSL_OFF_CTRL, 32'h80);
      tick(6);
      chk({rail_on, pg_oe_n, line}, {5'h1f, 2'b10});
      tick(30);
      chk({rail_on, pg_oe_n, line}, {5'h1f, 2'b11});
      wr(`PGSL_OFF_CTRL, 32'ha0);
      rdr(`PGSL_OFF_CTRL);
      chk(rd[5], 0);
      pulse(20);
      tick(26);
      chk({rail_on, pg_oe_n}, {5'h1f, 1'b1});
      // every listed event under both routings
      for (r = 1; r < 3; r = r + 1) begin
         wr(`PGSL_OFF_ROUTE, r);
         for (i = 0; i < 4; i = i + 1) begin
            @(posedge aclk);
            evt <= 7'h01 << i;
            tick(6);
            chk({alert_n, pg_oe_n}, {r == 2, 1'b1});
            @(posedge aclk);
            evt <= 7'h00;
            wr(`PGSL_OFF_CLEAR, 1 << i);
            tick(4);
            chk(alert_n, 1);
         end
      end
      wr(`PGSL_OFF_ROUTE, 1);
      wr(`PGSL_OFF_MASK, 32'h7e);
      evt <= 7'h01;
      tick(6);
      chk(alert_n, 1);
      rdr(`PGSL_OFF_STATUS);
      chk(rd[0], 1);
      evt <= 7'h00;
      wr(`PGSL_OFF_CLEAR, 1);
      wr(`PGSL_OFF_MASK, 32'h7f);
      // rail fault latches the line low until disable and enable
      @(posedge aclk);
      rgood <= 5'h1e;
      evt <= 7'h40;
      tick(6);
      chk(pg_oe_n, 0);
      @(posedge aclk);
      rgood <= 5'h1f;
      evt <= 7'h00;
      wr(`PGSL_OFF_CLEAR, 32'h40);
      tick(10);
      chk(pg_oe_n, 0);
      wr(`PGSL_OFF_CTRL, 0);
      wr(`PGSL_OFF_CTRL, 32'h80);
      tick(6);
      chk(pg_oe_n, 1);
      @(posedge aclk);
      evt <= 7'h10;
      tick(8);
      chk({alert_n, pg_oe_n}, 0);
      @(posedge aclk);
      evt <= 7'h00;
      wr(`PGSL_OFF_CLEAR, 32'h10);
      tick(6);
      chk({alert_n, pg_oe_n}, 0);
      // power cycle, then bidirectional use in programmable mode
      @(posedge aclk);
      aresetn <= 1'b0;
      smode <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      tick(2);
      chk(alert_n, 1);
      wr(`PGSL_OFF_CTRL, 32'h20);
      pulse(20);
      tick(26);
      wr(`PGSL_OFF_CTRL, 32'ha0);
      tick(8);
      chk({rail_on, pg_oe_n}, {5'h1f, 1'b1});
      rdr(`PGSL_OFF_STATE);
      chk(rd[2:0], 3'h6);
      pulse(2);
      tick(12);
      chk(rail_on, 5'h1f);
      pulse(20);
      tick(26);
      chk({rail_on, pg_oe_n}, 0);
      complete_run;
   end
endmodule // pgsl_top_tb_top
